/* design/img_interrupt_mask_gating.sv */
// Purpose: host interrupt mask, event status and interval timer over APB
// Assumes: event inputs are one-cycle pulses on clk_sys
// Notes: zero-wait reads need a setup cycle to load prdata
//
// Implementation choices: the register offsets and the APB slave port.

module img_interrupt_mask_gating
   import img_pkg::*;
#(
   parameter int EVENT_W = IMG_EVENT_W,
   parameter int PERIOD_W = IMG_PERIOD_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [IMG_ADDR_W-1:0] paddr,
   input wire logic [IMG_DATA_W-1:0] pwdata,
   output logic [IMG_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [EVENT_W-1:0] eventIn,
   output logic timerRunning,
   output logic irqOut
);

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   if (EVENT_W != IMG_EVENT_W)
   begin : g_bad_events
      $error("img_interrupt_mask_gating: EVENT_W must match the mask span");
   end
   if (PERIOD_W < 2 || PERIOD_W > IMG_PERIODIC_BIT)
   begin : g_bad_period
      $error("img_interrupt_mask_gating: PERIOD_W out of range");
   end

   // -----------------------------------------------------------------
   // APB phase and address decode
   // -----------------------------------------------------------------
   wire logic setupPhase = psel & ~penable;
   wire logic accessPhase = psel & penable;
   wire logic [7:0] regAddr = 8'(paddr);
   wire logic hitMask = (regAddr == IMG_MASK_OFS);
   wire logic hitStat = (regAddr == IMG_STAT_OFS);
   wire logic hitClr = (regAddr == IMG_CLR_OFS);
   wire logic hitPeriod = (regAddr == IMG_PERIOD_OFS);
   wire logic hitDoorbell = (regAddr == IMG_DOORBELL_OFS);
   wire logic hitAny = hitMask | hitStat | hitClr | hitPeriod
      | hitDoorbell;

   // Write strobes fire only on the completing access edge
   wire logic wrAccess = accessPhase & pwrite & hitAny;
   wire logic wrMask = wrAccess & hitMask;
   wire logic wrClr = wrAccess & hitClr;
   wire logic wrPeriod = wrAccess & hitPeriod;
   wire logic wrDoorbell = wrAccess & hitDoorbell;

   // Answer in the first access cycle; data was loaded at setup
   assign pready = accessPhase;
   assign pslverr = accessPhase & ~hitAny;

   // -----------------------------------------------------------------
   // Mask groups
   // -----------------------------------------------------------------
   logic [IMG_GROUP_W-1:0] maskLo;
   logic [IMG_GROUP_W-1:0] maskMid;
   logic [IMG_GROUP_W-1:0] maskHi;

   // Bits 7:1 under control bit 0; reserved 5:4 not implemented
   img_mask_group #(
      .W(IMG_GROUP_W),
      .IMPL(IMG_IMPL_LO)
   ) u_group_lo (
      .clk_sys(clk_sys),
      .rst(rst),
      .wrEn(wrMask),
      .ctrlBit(pwdata[IMG_CTRL_LO]),
      .wrBits(pwdata[IMG_CTRL_LO+1 +: IMG_GROUP_W]),
      .maskBits(maskLo)
   );

   // Bits 15:9 under control bit 8
   img_mask_group #(
      .W(IMG_GROUP_W),
      .IMPL(IMG_IMPL_MID)
   ) u_group_mid (
      .clk_sys(clk_sys),
      .rst(rst),
      .wrEn(wrMask),
      .ctrlBit(pwdata[IMG_CTRL_MID]),
      .wrBits(pwdata[IMG_CTRL_MID+1 +: IMG_GROUP_W]),
      .maskBits(maskMid)
   );

   // Bits 23:17 under control bit 16; none held in this block
   img_mask_group #(
      .W(IMG_GROUP_W),
      .IMPL(IMG_IMPL_HI)
   ) u_group_hi (
      .clk_sys(clk_sys),
      .rst(rst),
      .wrEn(wrMask),
      .ctrlBit(pwdata[IMG_CTRL_HI]),
      .wrBits(pwdata[IMG_CTRL_HI+1 +: IMG_GROUP_W]),
      .maskBits(maskHi)
   );

   // Control bits read as zero, being write-only
   wire logic [IMG_DATA_W-1:0] maskWord = {8'h00, maskHi, 1'b0,
      maskMid, 1'b0, maskLo, 1'b0};
   wire logic masterEnable = maskWord[IMG_MASTER_BIT];
   // Master enable is not an event gate itself
   wire logic [EVENT_W-1:0] eventGate = EVENT_W'(maskWord)
      & ~(EVENT_W'(1) << IMG_MASTER_BIT);

   // -----------------------------------------------------------------
   // Interval timer and its request doorbell
   // -----------------------------------------------------------------
   logic [PERIOD_W-1:0] period_reg;
   logic periodic_reg;
   logic timerExpire;
   wire logic descReq = pwdata[IMG_DESC_REQ_BIT];
   wire logic pktReq = pwdata[IMG_PKT_REQ_BIT];
   // Start pulses in the same cycle as the request write
   wire logic timerStart = wrDoorbell & (descReq | pktReq);

   // Period and mode software-held
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         period_reg <= PERIOD_W'(IMG_PERIOD_RST);
         periodic_reg <= 1'b0;
      end
      else if (wrPeriod)
      begin
         period_reg <= pwdata[PERIOD_W-1:0];
         periodic_reg <= pwdata[IMG_PERIODIC_BIT];
      end
   end

   img_interval_timer #(
      .PERIOD_W(PERIOD_W)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(timerStart),
      .periodic(periodic_reg),
      .period(period_reg),
      .expire(timerExpire),
      .running(timerRunning)
   );

   // -----------------------------------------------------------------
   // Sticky event status
   // -----------------------------------------------------------------
   logic [EVENT_W-1:0] status_reg;
   logic [EVENT_W-1:0] status_next;
   wire logic [EVENT_W-1:0] timerEvent = EVENT_W'(timerExpire)
      << IMG_TIMER_BIT;
   wire logic [EVENT_W-1:0] eventSet = eventIn | timerEvent;
   wire logic [EVENT_W-1:0] eventClr = wrClr ? pwdata[EVENT_W-1:0]
      : '0;

   // Set wins over a clear in the same cycle; master enable not consulted
   assign status_next = (status_reg & ~eventClr) | eventSet;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         status_reg <= '0;
      else
         status_reg <= status_next;
   end

   // -----------------------------------------------------------------
   // Host interrupt
   // -----------------------------------------------------------------
   // Combinational from flops so a new enable takes effect at once
   wire logic anyPending = |(status_reg & eventGate);
   assign irqOut = masterEnable & anyPending;

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   wire logic [IMG_DATA_W-1:0] statWord = IMG_DATA_W'(status_reg);
   wire logic [IMG_DATA_W-1:0] periodWord =
      IMG_DATA_W'(period_reg)
      | (IMG_DATA_W'(periodic_reg) << IMG_PERIODIC_BIT);
   // Clear and doorbell registers are write-only and read zero
   wire logic [IMG_DATA_W-1:0] rdSel =
      hitMask ? maskWord :
      hitStat ? statWord :
      hitPeriod ? periodWord :
      '0;

   // Loaded at setup so the access cycle can finish with no wait
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         prdata <= '0;
      else if (setupPhase & ~pwrite)
         prdata <= rdSel;
   end

endmodule : img_interrupt_mask_gating

/* design/img_interval_timer.sv */
// Purpose: one-shot or periodic interval timer
// Assumes: counts one tick per clk_sys cycle
// Notes: a start while running restarts the count

module img_interval_timer
   import img_pkg::*;
#(
   parameter int PERIOD_W = IMG_PERIOD_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   input wire logic periodic,
   input wire logic [PERIOD_W-1:0] period,
   output logic expire,
   output logic running
);

   if (PERIOD_W < 2)
   begin : g_bad_width
      $error("img_interval_timer: PERIOD_W must be at least two");
   end

   img_tmr_state_e state_reg;
   img_tmr_state_e state_next;
   logic [PERIOD_W-1:0] cnt_reg;
   logic [PERIOD_W-1:0] cnt_next;
   logic expire_next;
   // Zero and one both expire after a single tick
   wire logic lastTick = (cnt_reg <= PERIOD_W'(1));

   // Countdown sequencing
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      expire_next = 1'b0;
      case (state_reg)
         IMG_TMR_IDLE:
         begin
            if (start)
            begin
               state_next = IMG_TMR_RUN;
               cnt_next = period;
            end
         end
         IMG_TMR_RUN:
         begin
            if (start)
               cnt_next = period;
            else if (lastTick)
            begin
               expire_next = 1'b1;
               cnt_next = period;
               if (!periodic)
                  state_next = IMG_TMR_IDLE;
            end
            else
               cnt_next = cnt_reg - PERIOD_W'(1);
         end
         default:
         begin
            state_next = IMG_TMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= IMG_TMR_IDLE;
         cnt_reg <= '0;
         expire <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         expire <= expire_next;
      end
   end

   assign running = (state_reg == IMG_TMR_RUN);

endmodule : img_interval_timer

/* design/img_mask_group.sv */
// Purpose: one group of mask bits with its set/reset control
// Assumes: write strobe and data come from the same clock
// Notes: bits written as zero keep their value

module img_mask_group
   import img_pkg::*;
#(
   parameter int W = IMG_GROUP_W,
   parameter logic [W-1:0] IMPL = '1
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic ctrlBit,
   input wire logic [W-1:0] wrBits,
   output logic [W-1:0] maskBits
);

   // -----------------------------------------------------------------
   // Elaboration check
   // -----------------------------------------------------------------
   if (W < 1)
   begin : g_bad_width
      $error("img_mask_group: W must be at least one");
   end

   logic [W-1:0] mask_reg;
   logic [W-1:0] mask_next;
   wire logic [W-1:0] setVal = mask_reg | wrBits;
   wire logic [W-1:0] clrVal = mask_reg & ~wrBits;

   // Ones set or clear by control, zeros leave alone
   assign mask_next = (ctrlBit ? setVal : clrVal) & IMPL;

   // Unimplemented positions stay zero
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         mask_reg <= '0;
      else if (wrEn)
         mask_reg <= mask_next;
   end

   assign maskBits = mask_reg;

endmodule : img_mask_group

/* shared/img_pkg.sv */
// Purpose: constants and types shared by the interrupt mask gating block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets are byte addresses

package img_pkg;

   // -----------------------------------------------------------------
   // Bus and register map
   // -----------------------------------------------------------------
   localparam int IMG_DATA_W = 32;
   localparam int IMG_ADDR_W = 8;
   localparam logic [7:0] IMG_MASK_OFS = 8'h00;
   localparam logic [7:0] IMG_STAT_OFS = 8'h04;
   localparam logic [7:0] IMG_CLR_OFS = 8'h08;
   localparam logic [7:0] IMG_PERIOD_OFS = 8'h0C;
   localparam logic [7:0] IMG_DOORBELL_OFS = 8'h10;

   // -----------------------------------------------------------------
   // Mask register layout
   // -----------------------------------------------------------------
   localparam int IMG_GROUP_W = 7;
   localparam int IMG_CTRL_LO = 0;
   localparam int IMG_CTRL_MID = 8;
   localparam int IMG_CTRL_HI = 16;
   localparam int IMG_TXFIFO_BIT = 2;
   localparam int IMG_TXDONE_BIT = 3;
   localparam int IMG_TIMER_BIT = 6;
   localparam int IMG_MASTER_BIT = 7;
   localparam int IMG_RXCMD_BIT = 9;
   localparam int IMG_RXFIFO_BIT = 10;
   localparam int IMG_EVENT_W = 24;
   // Implemented bits per group, relative to the bit above its control
   localparam logic [6:0] IMG_IMPL_LO = 7'h66;
   localparam logic [6:0] IMG_IMPL_MID = 7'h03;
   localparam logic [6:0] IMG_IMPL_HI = 7'h00;
   localparam logic [6:0] IMG_MASK_RST = 7'h00;

   // -----------------------------------------------------------------
   // Interval timer
   // -----------------------------------------------------------------
   localparam int IMG_PERIOD_W = 24;
   localparam logic [23:0] IMG_PERIOD_RST = 24'h000000;
   localparam int IMG_PERIODIC_BIT = 31;
   localparam int IMG_DESC_REQ_BIT = 0;
   localparam int IMG_PKT_REQ_BIT = 1;

   typedef enum logic [1:0]
   {
      IMG_TMR_IDLE = 2'b01,
      IMG_TMR_RUN = 2'b10
   } img_tmr_state_e;

endpackage : img_pkg

/* verif/img_chk.sv */
// Purpose: assertions for the interrupt mask gating block
// Assumes: one clk_sys domain, zero-wait bus
// Notes: shadows mask, period and event status from bus traffic and eventIn
module img_chk
   import img_pkg::*;
#(
   parameter int EVENT_W = IMG_EVENT_W,
   parameter int PERIOD_W = IMG_PERIOD_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [IMG_ADDR_W-1:0] paddr,
   input wire logic [IMG_DATA_W-1:0] pwdata,
   input wire logic [IMG_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [EVENT_W-1:0] eventIn,
   input wire logic timerRunning,
   input wire logic irqOut
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Shadow state
   // ----------------------------------------------------------------
   logic [10:0] maskSh_reg;
   logic [EVENT_W-1:0] statSh_reg;
   logic [PERIOD_W:0] perSh_reg;
   logic [31:0] runCnt_reg;
   // Decode of bus accesses
   wire logic acc = psel & penable & pwrite;
   wire logic wrMask = acc & (paddr == IMG_MASK_OFS);
   wire logic wrClr = acc & (paddr == IMG_CLR_OFS);
   wire logic wrPer = acc & (paddr == IMG_PERIOD_OFS);
   wire logic kick = acc & (paddr == IMG_DOORBELL_OFS) & (|pwdata[1:0]);
   wire logic rdSet = psel & ~penable & ~pwrite;
   wire logic [10:0] hit = pwdata[10:0] & 11'h6CC;
   wire logic [10:0] grp = {{3{pwdata[8]}}, {8{pwdata[0]}}};
   wire logic [EVENT_W-1:0] clrBits = {EVENT_W{wrClr}} & pwdata[EVENT_W-1:0];
   // Timer bit 6 is not shadowed, so pend only under-predicts
   wire logic pend = maskSh_reg[7]
      & (|(statSh_reg[10:0] & maskSh_reg & 11'h67F));
   wire logic [PERIOD_W-1:0] per = perSh_reg[PERIOD_W-1:0];
   wire logic [31:0] expDur = (per == '0) ? 32'h00000001 : 32'(per);
   // Shadow registers follow the documented write semantics
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         maskSh_reg <= '0;
         statSh_reg <= '0;
         perSh_reg <= '0;
         runCnt_reg <= 32'h00000000;
      end
      else
      begin
         if (wrMask)
            maskSh_reg <= (maskSh_reg & ~hit) | (hit & grp);
         statSh_reg <= (statSh_reg & ~clrBits) | eventIn;
         if (wrPer)
            perSh_reg <= {pwdata[31], pwdata[PERIOD_W-1:0]};
         runCnt_reg <= (kick | ~timerRunning) ? 32'h00000000
            : runCnt_reg + 1;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_IRQ_ON: assert property (pend |-> irqOut)
      else $error("irq missing for enabled event");
   AST_IRQ_OFF: assert property (!maskSh_reg[7] |-> !irqOut)
      else $error("irq with master enable clear");
   AST_IRQ_CAUSE: assert property (irqOut |-> pend || maskSh_reg[6])
      else $error("irq without enabled cause");
   AST_RD_MASK: assert property (rdSet && paddr == IMG_MASK_OFS |=>
      prdata == {21'h000000, $past(maskSh_reg)})
      else $error("mask readback wrong");
   AST_CTRL_WO: assert property (rdSet && paddr == IMG_MASK_OFS |=>
      prdata[5:4] == 2'b00 && !prdata[0] && !prdata[8] && !prdata[16])
      else $error("control or reserved bit reads nonzero");
   AST_STAT_KEEP: assert property (rdSet && paddr == IMG_STAT_OFS |=>
      (prdata[EVENT_W-1:0] & $past(statSh_reg)) == $past(statSh_reg))
      else $error("status lost an event");
   AST_START: assert property (kick |=> timerRunning)
      else $error("timer did not start");
   AST_DUR: assert property ($fell(timerRunning)
      && !perSh_reg[PERIOD_W] |-> runCnt_reg == expDur)
      else $error("timer span wrong");
endmodule : img_chk

bind img_interrupt_mask_gating img_chk #(.EVENT_W(EVENT_W),
   .PERIOD_W(PERIOD_W)) u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .eventIn(eventIn),
   .timerRunning(timerRunning), .irqOut(irqOut));

/* verif/img_host_model.sv */
// Purpose: host side that takes the interrupt request
// Assumes: level request on clk_sys
// Notes: each new assertion counts as one interrupt taken
module img_host_model
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic irqOut,
   output logic [7:0] irqTaken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_reg;
   // Rising level is a fresh interrupt; a held level is not recounted
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         last_reg <= 1'b0;
         irqTaken <= 8'h00;
      end
      else
      begin
         last_reg <= irqOut;
         if (irqOut && !last_reg)
            irqTaken <= irqTaken + 8'h01;
      end
   end
endmodule : img_host_model

/* verif/tb.sv */
// Purpose: self-checking bench for the interrupt mask gating block
// Assumes: zero-wait APB slave, one clock
// Notes: bus tasks leave one idle cycle between transfers
module tb;
   import img_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [23:0] eventIn = 24'h000000;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, timerRunning, irqOut, errv;
   logic [7:0] irqTaken;
   int err_total = 0;
   int checks_done = 0;
   int n3, n6;
   int evb[4] = '{2, 3, 9, 10};
   img_interrupt_mask_gating u_dut (.clk_sys(clk_sys), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .eventIn(eventIn), .timerRunning(timerRunning), .irqOut(irqOut));
   img_host_model u_host (.clk_sys(clk_sys), .rst(rst), .irqOut(irqOut),
      .irqTaken(irqTaken));
   // Free-running system clock
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
      checks_done++;
      if (got !== ex)
      begin
         $display("wrong value %s expected %h seen %h", nm, ex, got);
         err_total++;
      end
   endtask : chk
   // Waits on pready rather than assuming zero wait
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      // No wait limit here: only the watchdog ends a stuck transfer
      while (pready !== 1'b1)
      begin
         @(posedge clk_sys);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic pulse(input int b);
      @(posedge clk_sys);
      eventIn <= 24'h000001 << b;
      @(posedge clk_sys);
      eventIn <= 24'h000000;
      #1;
   endtask : pulse
   task automatic wait_irq(output int n);
      n = 0;
      while (irqOut !== 1'b1)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : wait_irq
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // Watchdog: the sequence needs well under 2000 cycles
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      wrap_up();
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, IMG_MASK_OFS, 32'h0);
      chk("mask reset", 32'h0, rdv);
      apb(1'b0, 8'hFC, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, errv});
      apb(1'b1, IMG_MASK_OFS, 32'hFFFFFFFF);
      apb(1'b0, IMG_MASK_OFS, 32'h0);
      chk("mask all set", 32'h000006CC, rdv);
      // Clear 2 and 3, clear 9; the low group written zero keeps
      apb(1'b1, IMG_MASK_OFS, 32'h0000000C);
      apb(1'b1, IMG_MASK_OFS, 32'h00000201);
      apb(1'b0, IMG_MASK_OFS, 32'h0);
      chk("mask partial", 32'h000004C0, rdv);
      apb(1'b1, IMG_MASK_OFS, 32'h000006CC);
      // Events 2, 3, 9 and 10, first with master off then on
      foreach (evb[i])
      begin
         apb(1'b1, IMG_MASK_OFS, (32'h1 << evb[i]) | 32'h00000101);
         pulse(evb[i]);
         chk("irq master off", 32'h0, {31'h0, irqOut});
         apb(1'b0, IMG_STAT_OFS, 32'h0);
         chk("status kept", 32'h1 << evb[i], rdv);
         apb(1'b1, IMG_MASK_OFS, 32'h00000081);
         chk("irq master on", 32'h1, {31'h0, irqOut});
         apb(1'b1, IMG_CLR_OFS, 32'h00FFFFFF);
         chk("irq cleared", 32'h0, {31'h0, irqOut});
         apb(1'b1, IMG_MASK_OFS, 32'h000006CC);
      end
      // One-shot timer at two periods
      apb(1'b1, IMG_MASK_OFS, 32'h000000C1);
      apb(1'b1, IMG_PERIOD_OFS, 32'h00000003);
      apb(1'b1, IMG_DOORBELL_OFS, 32'h00000001);
      chk("timer runs", 32'h1, {31'h0, timerRunning});
      wait_irq(n3);
      apb(1'b0, IMG_STAT_OFS, 32'h0);
      chk("timer status", 32'h00000040, rdv);
      chk("one-shot idle", 32'h0, {31'h0, timerRunning});
      apb(1'b1, IMG_CLR_OFS, 32'h00000040);
      apb(1'b1, IMG_PERIOD_OFS, 32'h00000006);
      apb(1'b1, IMG_DOORBELL_OFS, 32'h00000002);
      wait_irq(n6);
      chk("period span", 32'h3, n6 - n3);
      // Periodic timer fires again after its status is cleared
      apb(1'b1, IMG_CLR_OFS, 32'h00000040);
      apb(1'b1, IMG_PERIOD_OFS, 32'h80000014);
      apb(1'b1, IMG_DOORBELL_OFS, 32'h00000001);
      wait_irq(n3);
      apb(1'b1, IMG_CLR_OFS, 32'h00000040);
      chk("periodic cleared", 32'h0, {31'h0, irqOut});
      wait_irq(n6);
      chk("periodic again", 32'h3, {30'h0, timerRunning, irqOut});
      @(posedge clk_sys);
      #1;
      chk("host irq count", 32'h8, {24'h0, irqTaken});
      wrap_up();
   end
endmodule : tb
